// file: atu_device.sv
`timescale 1ns/10ps
`include "atu_map.svh"
module atu_xlate_path #(
   parameter int ENTRIES = `ATU_TLB_ENTRIES,
   parameter int BLKS = `ATU_BLK_ENTRIES,
   parameter bit IS_DATA = 1'b0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire atu_pkg::atu_req_s req,
   input wire logic [23:0] vsid,
   input wire logic xlate_en,
   input wire logic supervisor,
   input wire logic [31:0] htab_base,
   input wire logic [18:0] htab_mask,
   input wire atu_pkg::atu_mnt_s mnt,
   input wire logic mnt_sel,
   input wire logic [23:0] mnt_vsid,
   output atu_pkg::atu_rsp_s rsp,
   output logic mem_valid
);
   import atu_pkg::*;
   localparam int SETS = ENTRIES / 2;
   localparam int IW = $clog2(SETS);
   localparam int TW = `ATU_VSID_W + 20 - IW;
   localparam int BW = (BLKS > 1) ? $clog2(BLKS) : 1;
   if (ENTRIES < 4 || ENTRIES > 1024 || (ENTRIES & (ENTRIES - 1)) != 0)
   begin : g_bad_entries
      $error("ENTRIES must be a power of two from 4 to 1024");
   end
   if (BLKS < 1 || BLKS > 16)
   begin : g_bad_blks
      $error("BLKS must be 1 to 16");
   end
   // page buffer: two ways per set, entry index {set, way} [RL13]
   logic [ENTRIES-1:0] valid_q;
   logic [TW-1:0] tag_q [ENTRIES];
   logic [19:0] ppn_q [ENTRIES];
   logic [1:0] pp_q [ENTRIES];
   logic [SETS-1:0] lru_q;
   logic [31:0] bup_q [BLKS];
   logic [31:0] blo_q [BLKS];
   atu_rsp_s rsp_q;
   logic mem_q;
   // page lookup, 4 KB pages under 256 MB segments [RL8] [RL10]
   wire [IW-1:0] set_w = req.ea[`ATU_PAGE_SHIFT+IW-1:`ATU_PAGE_SHIFT];
   wire [TW-1:0] tag_w = {vsid, req.ea[31:`ATU_PAGE_SHIFT+IW]};
   wire [IW:0] ix0 = {set_w, 1'b0};
   wire [IW:0] ix1 = {set_w, 1'b1};
   wire hit0 = valid_q[ix0] && (tag_q[ix0] == tag_w);
   wire hit1 = valid_q[ix1] && (tag_q[ix1] == tag_w);
   wire tlb_hit = hit0 || hit1;
   wire [19:0] tlb_ppn = hit1 ? ppn_q[ix1] : ppn_q[ix0];
   wire [1:0] tlb_pp = hit1 ? pp_q[ix1] : pp_q[ix0];
   // block arrays, mask bits widen the block from 128 KB to 256 MB [RL9] [RL17]
   logic [BLKS-1:0] blk_hit;
   logic [31:0] blk_pa [BLKS];
   logic [1:0] blk_pp [BLKS];
   for (genvar b = 0; b < BLKS; b++)
   begin : g_blk
      wire [14:0] blm = {4'h0, bup_q[b][`ATU_BLK_BL_MSB:`ATU_BLK_BL_LSB]};
      wire bvalid = supervisor ? bup_q[b][`ATU_BLK_VS] : bup_q[b][`ATU_BLK_VP];
      wire [14:0] epn = req.ea[31:`ATU_BLK_EPN_LSB];
      assign blk_hit[b] = bvalid && (((epn ^ bup_q[b][31:17]) & ~blm) == 15'h0);
      assign blk_pa[b] = {(blo_q[b][31:17] & ~blm) | (epn & blm), req.ea[16:0]};
      assign blk_pp[b] = blo_q[b][1:0];
   end
   // lowest index wins when blocks overlap
   logic [31:0] bsel_pa;
   logic [1:0] bsel_pp;
   always_comb
   begin
      bsel_pa = 32'h0;
      bsel_pp = 2'h0;
      for (int b = BLKS - 1; b >= 0; b--)
      begin
         if (blk_hit[b])
         begin
            bsel_pa = blk_pa[b];
            bsel_pp = blk_pp[b];
         end
      end
   end
   wire blk_any = |blk_hit;
   // key 1 for user state; 00 none, 01 and 11 read, 10 read/write
   wire user = !supervisor;
   wire store = IS_DATA && req.store;
   wire [1:0] pp_w = blk_any ? bsel_pp : tlb_pp;
   wire rd_ok = !user || (pp_w != 2'b00);
   wire wr_ok = (pp_w == 2'b10) || (!user && pp_w != 2'b11);
   wire prot_ok = store ? wr_ok : rd_ok; // [RL2]
   // block result is preferred over any page hit [RL23]
   wire mapped = blk_any || tlb_hit;
   wire [31:0] xl_pa = blk_any ? bsel_pa : {tlb_ppn, req.ea[11:0]};
   wire [31:0] pa_w = xlate_en ? xl_pa : req.ea; // [RL1] [RL6] [RL7]
   wire miss_w = xlate_en && !mapped;
   wire prot_w = xlate_en && mapped && !prot_ok; // [RL2]
   // miss vector by request class [RL3] [RL20] [RL21] [RL22]
   wire [15:0] miss_vec = !IS_DATA ? `ATU_VEC_IMISS : store ? `ATU_VEC_SMISS : `ATU_VEC_LMISS;
   wire [15:0] prot_vec = IS_DATA ? `ATU_VEC_DPROT : `ATU_VEC_IPROT;
   wire fault_w = miss_w || prot_w; // [RL11]
   wire [15:0] vec_w = miss_w ? miss_vec : prot_w ? prot_vec : 16'h0;
   // primary group address handed to the miss handler [RL14] [RL5]
   wire [18:0] hash_w = vsid[18:0] ^ {3'h0, req.ea[27:12]};
   wire [31:0] group_w = htab_base | {7'h0, hash_w & htab_mask, 6'h0};
   // maintenance decode
   wire m_on = mnt.valid && mnt_sel;
   wire [IW-1:0] m_set = mnt.addr[`ATU_PAGE_SHIFT+IW-1:`ATU_PAGE_SHIFT];
   wire m_inst = m_on && (mnt.op == ATU_OP_INST);
   wire m_inval = m_on && (mnt.op == ATU_OP_INVAL);
   wire m_blk = m_on && (mnt.op == ATU_OP_BLK);
   wire [IW:0] m_ix = {m_set, lru_q[m_set]};
   wire [BW-1:0] m_bidx = BW'(mnt.idx);
   wire hit_upd = req.valid && xlate_en && !blk_any && tlb_hit;
   // one registered stage: hit and miss both answer next cycle [RL12] [RL19]
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         rsp_q <= '0;
         mem_q <= 1'b0;
      end
      else
      begin
         rsp_q <= '{req.valid, req.valid && fault_w, vec_w, pa_w, group_w};
         mem_q <= req.valid && !fault_w; // [RL1]
      end
   end
   // buffer and block contents change only by maintenance [RL16] [RL18]
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         valid_q <= '0;
         lru_q <= '0;
         for (int b = 0; b < BLKS; b++)
            bup_q[b] <= 32'h0;
      end
      else
      begin
         if (hit_upd)
            lru_q[set_w] <= hit0; // [RL24]
         if (m_inst)
         begin
            valid_q[m_ix] <= 1'b1;
            lru_q[m_set] <= ~lru_q[m_set]; // [RL24]
         end
         if (m_inval)
         begin
            valid_q[{m_set, 1'b0}] <= 1'b0; // [RL15]
            valid_q[{m_set, 1'b1}] <= 1'b0; // [RL15]
         end
         if (m_blk)
            bup_q[m_bidx] <= mnt.addr;
      end
   end
   // payload arrays need no reset, guarded by valid bits
   always_ff @(posedge clk)
   begin
      if (m_inst)
      begin
         tag_q[m_ix] <= {mnt_vsid, mnt.addr[31:`ATU_PAGE_SHIFT+IW]};
         ppn_q[m_ix] <= mnt.data[19:0];
         pp_q[m_ix] <= mnt.data[`ATU_TLB_PP_MSB:`ATU_TLB_PP_LSB];
      end
      if (m_blk)
         blo_q[m_bidx] <= mnt.data;
   end
   assign rsp = rsp_q;
   assign mem_valid = mem_q;
endmodule

module atu_device #(
   parameter int ENTRIES = `ATU_TLB_ENTRIES,
   parameter int BLKS = `ATU_BLK_ENTRIES
) (
   atu_if.device bus,
   output logic mem_i_valid,
   output logic [31:0] mem_i_pa,
   output logic mem_d_valid,
   output logic [31:0] mem_d_pa
);
   import atu_pkg::*;
   localparam int NSEG = 16;
   logic [23:0] seg_q [NSEG];
   logic [31:0] hbase_q;
   logic [18:0] hmask_q;
   atu_rsp_s irsp_w;
   atu_rsp_s drsp_w;
   // segment number picks the VSID forming the 52-bit address [RL10]
   wire [23:0] ivsid = seg_q[bus.ireq.ea[`ATU_SEG_MSB:`ATU_SEG_LSB]];
   wire [23:0] dvsid = seg_q[bus.dreq.ea[`ATU_SEG_MSB:`ATU_SEG_LSB]];
   wire [23:0] mvsid = seg_q[bus.mnt.addr[`ATU_SEG_MSB:`ATU_SEG_LSB]];
   wire seg_wr = bus.mnt.valid && (bus.mnt.op == ATU_OP_SEG);
   wire htab_wr = bus.mnt.valid && (bus.mnt.op == ATU_OP_HTAB);
   always_ff @(posedge bus.clk)
   begin
      if (!bus.rst_n)
      begin
         hbase_q <= 32'h0;
         hmask_q <= 19'h0;
         for (int s = 0; s < NSEG; s++)
            seg_q[s] <= 24'h0;
      end
      else
      begin
         if (seg_wr)
            seg_q[bus.mnt.idx] <= bus.mnt.data[23:0];
         if (htab_wr)
         begin
            hbase_q <= bus.mnt.addr;
            hmask_q <= bus.mnt.data[18:0];
         end
      end
   end
   // independent instruction and data paths [RL3]
   atu_xlate_path #(.ENTRIES(ENTRIES), .BLKS(BLKS), .IS_DATA(1'b0)) u_ipath (
      .clk(bus.clk),
      .rst_n(bus.rst_n),
      .req(bus.ireq),
      .vsid(ivsid),
      .xlate_en(bus.instr_xlate_enable), // [RL6]
      .supervisor(bus.supervisor),
      .htab_base(hbase_q),
      .htab_mask(hmask_q),
      .mnt(bus.mnt),
      .mnt_sel(!bus.mnt.side),
      .mnt_vsid(mvsid),
      .rsp(irsp_w),
      .mem_valid(mem_i_valid)
   );
   atu_xlate_path #(.ENTRIES(ENTRIES), .BLKS(BLKS), .IS_DATA(1'b1)) u_dpath (
      .clk(bus.clk),
      .rst_n(bus.rst_n),
      .req(bus.dreq),
      .vsid(dvsid),
      .xlate_en(bus.data_xlate_enable), // [RL7]
      .supervisor(bus.supervisor),
      .htab_base(hbase_q),
      .htab_mask(hmask_q),
      .mnt(bus.mnt),
      .mnt_sel(bus.mnt.side),
      .mnt_vsid(mvsid),
      .rsp(drsp_w),
      .mem_valid(mem_d_valid)
   );
   assign bus.irsp = irsp_w;
   assign bus.drsp = drsp_w;
   assign mem_i_pa = irsp_w.pa;
   assign mem_d_pa = drsp_w.pa;
endmodule

// file: atu_map.svh
// Function
// [RL1] translate every effective address before memory
// [RL2] check access rights on blocks and pages
// [RL3] separate paths for fetches and data
// [RL4] page table size power of two, aligned
// [RL5] entry groups hold eight 8-byte entries
// [RL6] fetch translation only when instr enable set
// [RL7] data translation only when data enable set
// [RL8] 4 GB space, 4 KB pages, 256 MB segments
// [RL9] block sizes from 128 KB to 256 MB
// [RL10] 52-bit virtual address, 32-bit physical address
// [RL11] faults and violations raise exceptions
// [RL12] buffer hit adds no cycles
// [RL13] 64-entry two-way set-associative lookaside buffers
// [RL14] hardware assist for table search on miss
// [RL15] software invalidates single lookaside entries; the invalidate here clears both ways of the addressed set
// [RL16] software keeps buffers consistent with tables
// [RL17] four-entry block arrays per path
// [RL18] only software loads block arrays
// [RL19] load/store stage one translates, two accesses cache
// [RL20] fetch miss vectors to 01000
// [RL21] load miss vectors to 01100
// [RL22] store miss vectors to 01200
// [RL23] block translation beats page translation
// [RL24] least-recently-used way chosen on install
`ifndef ATU_MAP_SVH
`define ATU_MAP_SVH
`define ATU_PAGE_SHIFT 12
`define ATU_SEG_MSB 31
`define ATU_SEG_LSB 28
`define ATU_VSID_W 24
`define ATU_HASH_W 19
`define ATU_ENTRY_PER_GROUP 8
`define ATU_ENTRY_BYTES 8
`define ATU_GROUP_LOW 6'h3F
`define ATU_TLB_ENTRIES 64
`define ATU_BLK_ENTRIES 4
`define ATU_BLK_EPN_LSB 17
`define ATU_BLK_BL_MSB 12
`define ATU_BLK_BL_LSB 2
`define ATU_BLK_VS 1
`define ATU_BLK_VP 0
`define ATU_TLB_PP_MSB 21
`define ATU_TLB_PP_LSB 20
`define ATU_VEC_IMISS 16'h1000
`define ATU_VEC_LMISS 16'h1100
`define ATU_VEC_SMISS 16'h1200
`define ATU_VEC_IPROT 16'h0400
`define ATU_VEC_DPROT 16'h0300
`endif

// file: atu_pkg.sv
package atu_pkg;
   typedef enum logic [4:0] {
      ATU_OP_SEG = 5'h01,
      ATU_OP_HTAB = 5'h02,
      ATU_OP_INST = 5'h04,
      ATU_OP_INVAL = 5'h08,
      ATU_OP_BLK = 5'h10
   } atu_op_e;
   typedef struct packed {
      logic valid;
      logic store;
      logic [31:0] ea;
   } atu_req_s;
   typedef struct packed {
      logic valid;
      logic fault;
      logic [15:0] vector;
      logic [31:0] pa;
      logic [31:0] group;
   } atu_rsp_s;
   typedef struct packed {
      logic valid;
      atu_op_e op;
      logic side;
      logic [3:0] idx;
      logic [31:0] addr;
      logic [31:0] data;
   } atu_mnt_s;
endpackage

// file: atu_if.sv
`timescale 1ns/10ps
interface atu_if (
   input wire logic clk,
   input wire logic rst_n
);
   import atu_pkg::*;
   logic instr_xlate_enable;
   logic data_xlate_enable;
   logic supervisor;
   atu_req_s ireq;
   atu_req_s dreq;
   atu_mnt_s mnt;
   atu_rsp_s irsp;
   atu_rsp_s drsp;
   modport device (
      input clk,
      input rst_n,
      input instr_xlate_enable,
      input data_xlate_enable,
      input supervisor,
      input ireq,
      input dreq,
      input mnt,
      output irsp,
      output drsp
   );
   modport core (
      input clk,
      input rst_n,
      output instr_xlate_enable,
      output data_xlate_enable,
      output supervisor,
      output ireq,
      output dreq,
      output mnt,
      input irsp,
      input drsp
   );
endinterface

// file: atu_core_end.sv
`timescale 1ns/10ps
`include "atu_map.svh"
module atu_core_end (
   atu_if.core bus,
   input wire logic ixlate_on,
   input wire logic dxlate_on,
   input wire logic sup_state,
   input wire logic fetch_valid,
   input wire logic [31:0] fetch_ea,
   input wire logic data_valid,
   input wire logic data_store,
   input wire logic [31:0] data_ea,
   input wire logic cmd_valid,
   input wire atu_pkg::atu_op_e cmd_op,
   input wire logic cmd_side,
   input wire logic [3:0] cmd_idx,
   input wire logic [31:0] cmd_addr,
   input wire logic [31:0] cmd_data,
   output atu_pkg::atu_rsp_s fetch_rsp,
   output atu_pkg::atu_rsp_s data_rsp,
   output logic cmd_refused
);
   import atu_pkg::*;
   logic ixlate_q;
   logic dxlate_q;
   logic sup_q;
   atu_req_s ireq_q;
   atu_req_s dreq_q;
   atu_mnt_s mnt_q;
   atu_rsp_s frsp_q;
   atu_rsp_s drsp_q;
   logic refused_q;
   // table must be a power of two of 64-byte groups, base aligned to size
   wire [18:0] mask_w = cmd_data[18:0];
   wire mask_pow2 = ((mask_w & (mask_w + 19'h1)) == 19'h0); // [RL4]
   wire [31:0] size_m = {7'h0, mask_w, `ATU_GROUP_LOW}; // [RL5]
   wire base_ok = ((cmd_addr & size_m) == 32'h0); // [RL4]
   wire htab_bad = (cmd_op == ATU_OP_HTAB) && !(mask_pow2 && base_ok);
   wire cmd_take = cmd_valid && !htab_bad;
   always_ff @(posedge bus.clk)
   begin
      if (!bus.rst_n)
      begin
         ixlate_q <= 1'b0;
         dxlate_q <= 1'b0;
         sup_q <= 1'b1;
         ireq_q <= '0;
         dreq_q <= '0;
         mnt_q <= '0;
         frsp_q <= '0;
         drsp_q <= '0;
         refused_q <= 1'b0;
      end
      else
      begin
         ixlate_q <= ixlate_on;
         dxlate_q <= dxlate_on;
         sup_q <= sup_state;
         ireq_q <= '{fetch_valid, 1'b0, fetch_ea};
         dreq_q <= '{data_valid, data_store, data_ea};
         // tables change only on an explicit command [RL16] [RL18]
         mnt_q <= '{cmd_take, cmd_op, cmd_side, cmd_idx, cmd_addr, cmd_data};
         refused_q <= cmd_valid && htab_bad; // [RL4]
         frsp_q <= bus.irsp;
         drsp_q <= bus.drsp;
      end
   end
   assign bus.instr_xlate_enable = ixlate_q;
   assign bus.data_xlate_enable = dxlate_q;
   assign bus.supervisor = sup_q;
   assign bus.ireq = ireq_q;
   assign bus.dreq = dreq_q;
   assign bus.mnt = mnt_q;
   assign fetch_rsp = frsp_q;
   assign data_rsp = drsp_q;
   assign cmd_refused = refused_q;
endmodule

// file: atu_assertions.sv
`timescale 1ns/10ps
`include "atu_map.svh"
module atu_assertions (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic instr_xlate_enable,
   input wire logic data_xlate_enable,
   input wire logic supervisor,
   input wire atu_pkg::atu_req_s ireq,
   input wire atu_pkg::atu_req_s dreq,
   input wire atu_pkg::atu_mnt_s mnt,
   input wire atu_pkg::atu_rsp_s irsp,
   input wire atu_pkg::atu_rsp_s drsp
);
   import atu_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_ireq_off;
      ireq.valid && !instr_xlate_enable;
   endsequence
   sequence s_ipass;
      irsp.valid && !irsp.fault && irsp.pa == $past(ireq.ea);
   endsequence
   sequence s_load;
      dreq.valid && !dreq.store ##1 drsp.fault;
   endsequence
   sequence s_store;
      dreq.valid && dreq.store ##1 drsp.fault;
   endsequence
   property p_iansw;
      ireq.valid |=> irsp.valid;
   endproperty
   property p_dansw;
      dreq.valid |=> drsp.valid;
   endproperty
   property p_icause;
      irsp.valid |-> $past(ireq.valid);
   endproperty
   property p_ioff;
      s_ireq_off |=> s_ipass;
   endproperty
   property p_doff;
      dreq.valid && !data_xlate_enable |=>
         drsp.valid && !drsp.fault && drsp.pa == $past(dreq.ea);
   endproperty
   property p_ivec;
      irsp.valid && irsp.fault |-> irsp.vector inside {`ATU_VEC_IMISS, `ATU_VEC_IPROT};
   endproperty
   property p_lvec;
      s_load |-> drsp.vector inside {`ATU_VEC_LMISS, `ATU_VEC_DPROT};
   endproperty
   property p_svec;
      s_store |-> drsp.vector inside {`ATU_VEC_SMISS, `ATU_VEC_DPROT};
   endproperty
   property p_group;
      irsp.valid |-> irsp.group[5:0] == 6'h00;
   endproperty
   // low page bits always pass through translation unchanged
   property p_pgoff;
      ireq.valid && instr_xlate_enable |=>
         irsp.fault || irsp.pa[11:0] == $past(ireq.ea[11:0]);
   endproperty
   a_iansw: assert property (p_iansw) else $error("fetch answer late");
   a_dansw: assert property (p_dansw) else $error("data answer late");
   a_icause: assert property (p_icause) else $error("fetch answer unasked");
   a_ioff: assert property (p_ioff) else $error("fetch not passed through");
   a_doff: assert property (p_doff) else $error("data not passed through");
   a_ivec: assert property (p_ivec) else $error("fetch vector wrong");
   a_lvec: assert property (p_lvec) else $error("load vector wrong");
   a_svec: assert property (p_svec) else $error("store vector wrong");
   a_group: assert property (p_group) else $error("group unaligned");
   a_pgoff: assert property (p_pgoff) else $error("page offset changed");
endmodule

// file: atu_tb_top.sv
`timescale 1ns/10ps
module address_translation_unit_tb_top;
   import atu_pkg::*;
   typedef struct packed {
      logic [4:0] f;
      logic [15:0] vec;
      logic [31:0] ea;
      logic [31:0] pa;
      logic [31:0] grp;
   } atu_row_s;
   logic clk = 1'b0, rst_n = 1'b0, rf;
   logic ixlate_on = 1'b0, dxlate_on = 1'b0, sup_state = 1'b0, fetch_valid = 1'b0;
   logic [3:0] cmd_idx = 4'h0;
   logic data_valid = 1'b0, data_store = 1'b0, cmd_valid = 1'b0, cmd_side = 1'b0;
   logic [31:0] fetch_ea = 32'h0, data_ea = 32'h0, cmd_addr = 32'h0, cmd_data = 32'h0;
   atu_op_e cmd_op = ATU_OP_SEG;
   atu_rsp_s fetch_rsp, data_rsp;
   logic cmd_refused, mem_i_valid, mem_d_valid;
   logic [31:0] mem_i_pa, mem_d_pa;
   int mismatches = 0, cmp_count = 0, cycles = 0, nf, nd;
   // f: data, store, supervisor, enable, fault
   atu_row_s rows [11] = '{'{5'h06, 16'h0, 32'h00005123, 32'hABCDE123, 32'h0},
      '{5'h02, 16'h0, 32'h00005123, 32'hABCDE123, 32'h0},
      '{5'h07, 16'h1000, 32'h00007000, 32'h0, 32'h00010900},
      '{5'h16, 16'h0, 32'h00005456, 32'h12345456, 32'h0},
      '{5'h17, 16'h1100, 32'h00007000, 32'h0, 32'h00010900},
      '{5'h1F, 16'h1200, 32'h00007000, 32'h0, 32'h0},
      '{5'h16, 16'h0, 32'h00401ABC, 32'h00801ABC, 32'h0},
      '{5'h1E, 16'h0, 32'h00005000, 32'h12345000, 32'h0},
      '{5'h1B, 16'h0300, 32'h00005000, 32'h0, 32'h0},
      '{5'h04, 16'h0, 32'h00007000, 32'h00007000, 32'h0},
      '{5'h1C, 16'h0, 32'h00007000, 32'h00007000, 32'h0}};
   always #20 clk = ~clk;
   atu_if atu_if_inst (.clk(clk), .rst_n(rst_n));
   atu_device atu_device_inst (.bus(atu_if_inst.device), .mem_i_valid(mem_i_valid),
      .mem_i_pa(mem_i_pa), .mem_d_valid(mem_d_valid), .mem_d_pa(mem_d_pa));
   atu_core_end atu_core_end_inst (.bus(atu_if_inst.core), .ixlate_on(ixlate_on),
      .dxlate_on(dxlate_on), .sup_state(sup_state), .fetch_valid(fetch_valid),
      .fetch_ea(fetch_ea), .data_valid(data_valid), .data_store(data_store),
      .data_ea(data_ea), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_side(cmd_side),
      .cmd_idx(cmd_idx), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .fetch_rsp(fetch_rsp),
      .data_rsp(data_rsp), .cmd_refused(cmd_refused));
   atu_assertions atu_assertions_inst (.clk(clk), .rst_n(rst_n),
      .instr_xlate_enable(atu_if_inst.instr_xlate_enable),
      .data_xlate_enable(atu_if_inst.data_xlate_enable),
      .supervisor(atu_if_inst.supervisor), .ireq(atu_if_inst.ireq), .dreq(atu_if_inst.dreq),
      .mnt(atu_if_inst.mnt), .irsp(atu_if_inst.irsp), .drsp(atu_if_inst.drsp));
   task automatic results();
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic ok, input string m);
      cmp_count++;
      if (ok !== 1'b1)
      begin
         mismatches++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask
   task automatic cmd(input atu_op_e op, input logic s, input logic [31:0] a, d);
      cmd_valid = 1'b1;
      cmd_op = op;
      cmd_side = s;
      cmd_addr = a;
      cmd_data = d;
      rf = 1'b0;
      // strobe dropped once, so the next call may raise it in its own step
      @(posedge clk);
      #1;
      cmd_valid = 1'b0;
      // five edges in all also let the write take effect
      repeat (4)
      begin
         if (cmd_refused === 1'b1)
            rf = 1'b1;
         @(posedge clk);
         #1;
      end
   endtask
   task automatic tx(input atu_row_s w);
      atu_rsp_s r;
      logic mv;
      logic [31:0] mpa;
      r = '0;
      mv = 1'b0;
      mpa = 32'h0;
      fetch_valid = ~w.f[4];
      data_valid = w.f[4];
      data_store = w.f[3];
      sup_state = w.f[2];
      ixlate_on = w.f[1];
      dxlate_on = w.f[1];
      fetch_ea = w.ea;
      data_ea = w.ea;
      for (int n = 0; n < 10 && r.valid !== 1'b1; n++)
      begin
         @(posedge clk);
         #1;
         // dropped on the first edge only, never in the step a next call starts
         if (n == 0)
         begin
            fetch_valid = 1'b0;
            data_valid = 1'b0;
         end
         if ((w.f[4] ? mem_d_valid : mem_i_valid) === 1'b1)
         begin
            mv = 1'b1;
            mpa = w.f[4] ? mem_d_pa : mem_i_pa;
         end
         r = w.f[4] ? data_rsp : fetch_rsp;
      end
      chk(r.valid === 1'b1 && r.fault === w.f[0], "fault");
      chk(w.f[0] ? r.vector === w.vec : r.pa === w.pa && mpa === w.pa, "address");
      chk(mv === ~w.f[0], "memory pass");
      chk(w.grp == 32'h0 || r.group === w.grp, "group");
   endtask
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         mismatches++;
         $display("[ERR] %0t timeout", $time);
         results();
      end
   end
   initial
   begin
      repeat (20) @(posedge clk);
      #1;
      rst_n = 1'b1;
      cmd(ATU_OP_HTAB, 1'b0, 32'h00010000, 32'h0000003F);
      chk(rf === 1'b0, "table accepted");
      cmd(ATU_OP_SEG, 1'b0, 32'h0, 32'h00000123);
      cmd(ATU_OP_INST, 1'b0, 32'h00005000, 32'h002ABCDE);
      cmd(ATU_OP_INST, 1'b0, 32'h00006000, 32'h00266666);
      cmd(ATU_OP_INST, 1'b1, 32'h00005000, 32'h00012345);
      cmd(ATU_OP_INST, 1'b1, 32'h00401000, 32'h00255555);
      cmd(ATU_OP_BLK, 1'b1, 32'h00400003, 32'h00800002);
      foreach (rows[k])
      begin
         tx(rows[k]);
         $display("row %0d done", k);
      end
      // last entry of the fetch block array, user valid, read only
      cmd_idx = 4'h3;
      cmd(ATU_OP_BLK, 1'b0, 32'h00600001, 32'h00A00001);
      cmd_idx = 4'h0;
      tx('{5'h02, 16'h0, 32'h00600010, 32'h00A00010, 32'h0});
      $display("block entry done");
      cmd(ATU_OP_INVAL, 1'b0, 32'h00005000, 32'h0);
      tx('{5'h07, 16'h1000, 32'h00005123, 32'h0, 32'h0});
      tx('{5'h06, 16'h0, 32'h00006010, 32'h66666010, 32'h0});
      $display("invalidate done");
      // both installs land in set 5, the second evicts the older way
      cmd(ATU_OP_INST, 1'b1, 32'h00025000, 32'h00222222);
      cmd(ATU_OP_INST, 1'b1, 32'h00045000, 32'h00244444);
      tx('{5'h17, 16'h1100, 32'h00005000, 32'h0, 32'h0});
      tx('{5'h16, 16'h0, 32'h00025000, 32'h22222000, 32'h0});
      tx('{5'h16, 16'h0, 32'h00045000, 32'h44444000, 32'h0});
      $display("replacement done");
      cmd(ATU_OP_HTAB, 1'b0, 32'h00010000, 32'h0000003E);
      chk(rf === 1'b1, "mask refused");
      cmd(ATU_OP_HTAB, 1'b0, 32'h00010040, 32'h0000003F);
      chk(rf === 1'b1, "base refused");
      tx('{5'h07, 16'h1000, 32'h00007000, 32'h0, 32'h00010900});
      $display("table refusal done");
      fetch_valid = 1'b1;
      data_valid = 1'b1;
      fetch_ea = 32'h00006000;
      data_ea = 32'h00025000;
      repeat (2) @(posedge clk);
      #1;
      fetch_valid = 1'b0;
      data_valid = 1'b0;
      nf = 0;
      nd = 0;
      repeat (8)
      begin
         @(posedge clk);
         #1;
         nf += (fetch_rsp.valid === 1'b1);
         nd += (data_rsp.valid === 1'b1);
      end
      chk(nf == 2 && nd == 2, "concurrent answers");
      $display("concurrent done");
      rst_n = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk(fetch_rsp === '0 && mem_i_valid === 1'b0 && mem_d_valid === 1'b0, "reset");
      rst_n = 1'b1;
      tx('{5'h07, 16'h1000, 32'h00006010, 32'h0, 32'h0});
      $display("reset done");
      results();
   end
endmodule
